// *** pac_defs.svh ***
`ifndef PAC_DEFS_SVH
`define PAC_DEFS_SVH
// register indices on the management bus
`define PAC_REG_CONTROL 5'h00
`define PAC_REG_STATUS 5'h01
`define PAC_REG_ADVERT 5'h04
`define PAC_REG_PARTNER 5'h05
`define PAC_REG_EXPANSION 5'h06
`define PAC_REG_SUMMARY 5'h10
`define PAC_REG_PORTCTL 5'h19
// control register fields
`define PAC_CTL_SPEED 13
`define PAC_CTL_NEG_EN 12
`define PAC_CTL_ISOLATE 10
`define PAC_CTL_RESTART 9
`define PAC_CTL_DUPLEX 8
// port control fields
`define PAC_PCR_AUTO_XOVER 15
`define PAC_PCR_FORCE_XOVER 14
// reset values
`define PAC_CONTROL_RST 16'h3000
`define PAC_ADVERT_RST 16'h01e1
`define PAC_PORTCTL_RST 16'h8000
`define PAC_STATUS_ABIL 16'h7849
// parallel detect partner images
`define PAC_PD_100 16'h0081
`define PAC_PD_10 16'h0021
// break link time in ms, and the clock rate in kHz
`define PAC_BREAK_MS 1500
`define PAC_CLK_KHZ 125000
`define PAC_BREAK_CYC (`PAC_BREAK_MS * `PAC_CLK_KHZ)
`endif

// *** pac_pkg.sv ***
package pac_pkg;
  typedef enum logic [2:0] {
    PAC_IDLE, PAC_BREAK, PAC_FLP, PAC_PDET, PAC_LINK, PAC_FORCED
  } pac_state_e;
  typedef logic [15:0] pac_word_t;
endpackage

// *** pac_mode_resolve.sv ***
`timescale 1ns/1ps
// picks the best common mode from two ability words
module pac_mode_resolve (
  input wire logic [15:0] local_in,
  input wire logic [15:0] partner_in,
  output logic speed100_out,
  output logic full_out,
  output logic none_out
);
  logic [3:0] common;
  always_comb begin
    common = local_in[8:5] & partner_in[8:5];
    speed100_out = 1'b0;
    full_out = 1'b0;
    none_out = 1'b0;
    if (common[3]) begin
      speed100_out = 1'b1;
      full_out = 1'b1;
    end else if (common[2]) begin
      speed100_out = 1'b1;
    end else if (common[1]) begin
      full_out = 1'b1;
    end else if (!common[0]) begin
      none_out = 1'b1;
    end
  end
endmodule

// *** pac_negotiation.sv ***
`timescale 1ns/1ps
`include "pac_defs.svh"
// Summary of operation
// - send advertisement word in link bursts
// - resolve 100FD, 100HD, 10FD, 10HD order
// - control register enables and restarts negotiation
// - forced speed and duplex when negotiation off
// - report resolved speed in summary register
// - status ability bits constant, T4 zero
// - advertise all by default, writes clear
// - partner register captures received code words
// - parallel detect loads 0081h or 0021h
// - expansion register reports negotiation flags
// - exactly one receiver's link picks parallel technology
// - parallel complete reads partner-able zero
// - fault unless exactly one good link
// - restart bit with enable set restarts negotiation, after a forced start only once enable was cleared
// - lost negotiated link resumes negotiation
// - break link timer silences before bursts
// - auto crossover default on, off forced
// - force crossover bit crosses pairs always
// - strapped station address latched at reset
// - isolate ignores tx, tristates mii outputs
// - isolated line keeps idles and negotiation
module pac_negotiation #(
  parameter int unsigned BREAK_CYCLES = `PAC_BREAK_CYC,
  parameter logic PORT_B = 1'b0
) (
  input wire logic CLK_SYS_IN,
  input wire logic RESET_N_IN,
  input wire logic [3:0] ADDR_STRAP_IN,
  input wire logic MGMT_WR_IN,
  input wire logic MGMT_RD_IN,
  input wire logic [4:0] MGMT_REG_IN,
  input wire logic [15:0] MGMT_WDATA_IN,
  output pac_pkg::pac_word_t MGMT_RDATA_OUT,
  input wire logic LINK10_IN,
  input wire logic LINK100_IN,
  input wire logic PAGE_VALID_IN,
  input wire logic [15:0] PAGE_WORD_IN,
  input wire logic PARTNER_FLP_IN,
  input wire logic TX_EN_IN,
  input wire logic [3:0] TXD_IN,
  output logic LINE_TX_EN_OUT,
  output logic [3:0] LINE_TXD_OUT,
  output logic FLP_SEND_OUT,
  output pac_pkg::pac_word_t FLP_WORD_OUT,
  output logic IDLE_SEND_OUT,
  output logic MII_OE_OUT,
  output logic SPEED100_OUT,
  output logic FULL_DUPLEX_OUT,
  output logic LINK_UP_OUT,
  output logic CROSSOVER_OUT,
  output logic [4:0] STATION_ADDR_OUT
);
  import pac_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  pac_state_e state, next_state;
  logic [15:0] control, next_control;
  logic [15:0] advert, next_advert;
  logic [15:0] partner, next_partner;
  logic [15:0] portctl, next_portctl;
  logic [31:0] timer, next_timer;
  logic complete, next_complete;
  logic pd_fault, next_pd_fault;
  logic page_rx, next_page_rx;
  logic partner_able, next_partner_able;
  logic speed, next_speed;
  logic full, next_full;
  logic xover, next_xover;
  logic [7:0] lfsr, next_lfsr;
  logic strap_done, next_strap_done;
  logic forced_start, next_forced_start;
  logic en_cleared, next_en_cleared;
  logic res_speed, res_full, res_none;

  pac_mode_resolve u_resolve (
    .local_in(advert),
    .partner_in(partner),
    .speed100_out(res_speed),
    .full_out(res_full),
    .none_out(res_none)
  );

  logic wr_ctl, wr_adv, wr_pcr, neg_en, restart_req, link_ok;
  always_comb begin
    wr_ctl = MGMT_WR_IN && (MGMT_REG_IN == `PAC_REG_CONTROL);
    wr_adv = MGMT_WR_IN && (MGMT_REG_IN == `PAC_REG_ADVERT);
    wr_pcr = MGMT_WR_IN && (MGMT_REG_IN == `PAC_REG_PORTCTL);
    neg_en = control[`PAC_CTL_NEG_EN];
    // after a forced start, enable must see a clear first
    restart_req = wr_ctl && MGMT_WDATA_IN[`PAC_CTL_RESTART] &&
                  MGMT_WDATA_IN[`PAC_CTL_NEG_EN] &&
                  (!forced_start || en_cleared);
    link_ok = speed ? LINK100_IN : LINK10_IN;
  end

  // ---------------------------------------------------------------
  // registers and negotiation sequence
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_control = control;
    next_advert = advert;
    next_partner = partner;
    next_portctl = portctl;
    next_timer = timer;
    next_complete = complete;
    next_pd_fault = pd_fault;
    next_page_rx = page_rx;
    next_partner_able = partner_able;
    next_speed = speed;
    next_full = full;
    next_xover = xover;
    next_lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    next_strap_done = 1'b1;
    next_forced_start = strap_done ? forced_start : !neg_en;
    next_en_cleared = en_cleared;
    if (!strap_done) begin
      next_portctl[4:0] = {ADDR_STRAP_IN, PORT_B};
    end
    if (MGMT_RD_IN && (MGMT_REG_IN == `PAC_REG_EXPANSION)) begin
      next_page_rx = 1'b0;
      next_pd_fault = 1'b0;
    end
    if (wr_ctl) begin
      next_control = MGMT_WDATA_IN & 16'hf5ff;
      if (!MGMT_WDATA_IN[`PAC_CTL_NEG_EN]) begin
        next_en_cleared = 1'b1;
      end
    end
    if (wr_adv) begin
      next_advert = {MGMT_WDATA_IN[15:5], 5'h01};
    end
    if (wr_pcr) begin
      next_portctl[15:5] = MGMT_WDATA_IN[15:5];
    end
    if (restart_req || (wr_ctl && MGMT_WDATA_IN[`PAC_CTL_NEG_EN] &&
        !neg_en && (!forced_start || en_cleared))) begin
      next_state = PAC_BREAK;
      next_timer = '0;
      next_complete = 1'b0;
      next_forced_start = 1'b0;
    end else if (wr_ctl && !MGMT_WDATA_IN[`PAC_CTL_NEG_EN]) begin
      next_state = PAC_FORCED;
    end else begin
      case (state)
        PAC_IDLE: begin
          next_state = neg_en ? PAC_BREAK : PAC_FORCED;
          next_timer = '0;
        end
        PAC_BREAK: begin
          next_timer = timer + 32'h1;
          if (timer >= BREAK_CYCLES - 1) begin
            next_state = PAC_FLP;
          end
        end
        PAC_FLP: begin
          if (PAGE_VALID_IN) begin
            next_partner = PAGE_WORD_IN;
            next_page_rx = 1'b1;
            next_partner_able = 1'b1;
            if (!PAGE_WORD_IN[15]) begin
              next_state = PAC_LINK;
              next_complete = 1'b1;
            end
          end else if (!PARTNER_FLP_IN && (LINK10_IN || LINK100_IN)) begin
            next_state = PAC_PDET;
          end
        end
        PAC_PDET: begin
          if (LINK10_IN ^ LINK100_IN) begin
            next_partner = LINK100_IN ? `PAC_PD_100 : `PAC_PD_10;
            next_partner_able = 1'b0;
            next_complete = 1'b1;
            next_speed = LINK100_IN;
            next_full = 1'b0;
            next_state = PAC_LINK;
          end else begin
            next_pd_fault = 1'b1;
            next_state = PAC_FLP;
          end
        end
        PAC_LINK: begin
          if (partner_able && complete && next_partner == partner) begin
            next_speed = res_speed;
            next_full = res_full;
          end
          // judge the link on the speed being taken, not the stale one
          if (!(next_speed ? LINK100_IN : LINK10_IN) ||
              (res_none && partner_able)) begin
            next_state = PAC_BREAK;
            next_timer = '0;
            next_complete = 1'b0;
          end
        end
        PAC_FORCED: begin
          next_speed = control[`PAC_CTL_SPEED];
          next_full = control[`PAC_CTL_DUPLEX];
          next_complete = 1'b0;
        end
        default: next_state = PAC_IDLE;
      endcase
    end
    // crossover: forced wins, auto only while negotiating
    if (portctl[`PAC_PCR_FORCE_XOVER]) begin
      next_xover = 1'b1;
    end else if (portctl[`PAC_PCR_AUTO_XOVER] && state == PAC_FLP &&
                 lfsr[2:0] == 3'h0) begin
      next_xover = ~xover;
    end else if (state == PAC_FORCED) begin
      next_xover = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state <= PAC_IDLE;
      control <= `PAC_CONTROL_RST;
      advert <= `PAC_ADVERT_RST;
      partner <= 16'h0000;
      portctl <= `PAC_PORTCTL_RST;
      timer <= '0;
      complete <= 1'b0;
      pd_fault <= 1'b0;
      page_rx <= 1'b0;
      partner_able <= 1'b0;
      speed <= 1'b0;
      full <= 1'b0;
      xover <= 1'b0;
      lfsr <= 8'h5a;
      strap_done <= 1'b0;
      forced_start <= 1'b0;
      en_cleared <= 1'b0;
    end else begin
      state <= next_state;
      control <= next_control;
      advert <= next_advert;
      partner <= next_partner;
      portctl <= next_portctl;
      timer <= next_timer;
      complete <= next_complete;
      pd_fault <= next_pd_fault;
      page_rx <= next_page_rx;
      partner_able <= next_partner_able;
      speed <= next_speed;
      full <= next_full;
      xover <= next_xover;
      lfsr <= next_lfsr;
      strap_done <= next_strap_done;
      forced_start <= next_forced_start;
      en_cleared <= next_en_cleared;
    end
  end

  // ---------------------------------------------------------------
  // read data, line and mii outputs
  // ---------------------------------------------------------------
  logic [15:0] next_rdata, rdata;
  logic [3:0] next_txd, txd;
  logic next_txen, txen;
  always_comb begin
    next_rdata = 16'h0000;
    if (MGMT_REG_IN == `PAC_REG_CONTROL) begin
      next_rdata = control;
    end else if (MGMT_REG_IN == `PAC_REG_STATUS) begin
      next_rdata = `PAC_STATUS_ABIL;
      next_rdata[5] = complete;
      next_rdata[2] = (state == PAC_LINK || state == PAC_FORCED) && link_ok;
    end else if (MGMT_REG_IN == `PAC_REG_ADVERT) begin
      next_rdata = advert;
    end else if (MGMT_REG_IN == `PAC_REG_PARTNER) begin
      next_rdata = partner;
    end else if (MGMT_REG_IN == `PAC_REG_EXPANSION) begin
      next_rdata = {11'h000, pd_fault, partner[15], advert[15], page_rx,
                    partner_able};
    end else if (MGMT_REG_IN == `PAC_REG_SUMMARY) begin
      next_rdata = {11'h000, complete, 1'b0, full, !speed,
                    LINK_UP_OUT};
    end else if (MGMT_REG_IN == `PAC_REG_PORTCTL) begin
      next_rdata = portctl;
    end
    // isolate drops mac data; data only once a mode is settled
    next_txen = TX_EN_IN && !control[`PAC_CTL_ISOLATE] &&
                (state == PAC_LINK || state == PAC_FORCED);
    next_txd = next_txen ? TXD_IN : 4'h0;
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rdata <= 16'h0000;
      txd <= 4'h0;
      txen <= 1'b0;
    end else begin
      rdata <= next_rdata;
      txd <= next_txd;
      txen <= next_txen;
    end
  end

  always_comb begin
    MGMT_RDATA_OUT = rdata;
    LINE_TX_EN_OUT = txen;
    LINE_TXD_OUT = txd;
    FLP_SEND_OUT = (state == PAC_FLP) && neg_en;
    FLP_WORD_OUT = advert;
    IDLE_SEND_OUT = (state == PAC_LINK || state == PAC_FORCED);
    MII_OE_OUT = !control[`PAC_CTL_ISOLATE];
    SPEED100_OUT = speed;
    FULL_DUPLEX_OUT = full;
    LINK_UP_OUT = (state == PAC_LINK || state == PAC_FORCED) && link_ok;
    CROSSOVER_OUT = xover;
    STATION_ADDR_OUT = portctl[4:0];
  end
endmodule

// *** pac_negotiation_assertions.sv ***
`timescale 1ns/1ps
// ------------------------------
// port checker
// ------------------------------
module pac_neg_chk #(
  parameter logic PORT_B = 1'b0
) (
  input wire logic CLK_SYS_IN,
  input wire logic RESET_N_IN,
  input wire logic MGMT_WR_IN,
  input wire logic [4:0] MGMT_REG_IN,
  input wire pac_pkg::pac_word_t MGMT_RDATA_OUT,
  input wire logic LINE_TX_EN_OUT,
  input wire logic FLP_SEND_OUT,
  input wire logic IDLE_SEND_OUT,
  input wire logic MII_OE_OUT,
  input wire logic LINK_UP_OUT,
  input wire logic CROSSOVER_OUT,
  input wire logic [4:0] STATION_ADDR_OUT
);
  import pac_pkg::*;
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESET_N_IN);
  a_status_fixed: assert property (
    MGMT_REG_IN == 5'h01 |=> (MGMT_RDATA_OUT & 16'hf809) == 16'h7809)
    else $error("status ability bits wrong");
  a_isolate_no_tx: assert property (
    !MII_OE_OUT [*2] |-> !LINE_TX_EN_OUT)
    else $error("line sends while isolated");
  a_isolate_idles: assert property (
    !MII_OE_OUT && LINK_UP_OUT |-> IDLE_SEND_OUT)
    else $error("isolated link sends no idles");
  a_burst_after_quiet: assert property (
    $rose(FLP_SEND_OUT) |-> !LINE_TX_EN_OUT && !IDLE_SEND_OUT)
    else $error("bursts start on a busy line");
  a_burst_no_data: assert property (
    FLP_SEND_OUT [*2] |-> !LINE_TX_EN_OUT)
    else $error("data sent during bursts");
  a_break_holds: assert property (
    $fell(LINK_UP_OUT) |-> !FLP_SEND_OUT [*8])
    else $error("bursts before break time");
  a_addr_port_bit: assert property (
    $past(RESET_N_IN) |-> STATION_ADDR_OUT[0] == PORT_B)
    else $error("station address port bit wrong");
  a_xover_still: assert property (
    !$past(FLP_SEND_OUT) && !$past(MGMT_WR_IN) && !$past(MGMT_WR_IN, 2)
    |-> $stable(CROSSOVER_OUT))
    else $error("crossover moved outside bursts");
  c_bursts: cover property ($rose(FLP_SEND_OUT));
  c_iso_link: cover property (LINK_UP_OUT && !MII_OE_OUT);
  c_link_lost: cover property ($fell(LINK_UP_OUT));
endmodule
bind pac_negotiation pac_neg_chk #(.PORT_B(PORT_B)) u_chk (.*);

// *** pac_link_partner.sv ***
`timescale 1ns/1ps
// ------------------------------
// remote partner model
// ------------------------------
module pac_link_partner (
  input wire logic clk_in,
  input wire logic flp_in,
  input wire logic idle_in,
  input wire logic neg_in,
  input wire logic [3:0] lag_in,
  input wire logic [1:0] link_in,
  input wire logic [15:0] word_in,
  output logic link10_out,
  output logic link100_out,
  output logic page_valid_out = 1'b0,
  output logic flp_out,
  output logic [15:0] page_word_out = 16'h0000
);
  int n = 0;
  logic up = 1'b0;
  // answers our bursts after lag_in cycles; drops link on a silent line
  always @(negedge clk_in) begin
    n = (flp_in && neg_in) ? n + 1 : 0;
    page_valid_out <= (n == lag_in);
    page_word_out <= (n == lag_in) ? word_in : ~page_word_out;
    if (n == lag_in)
      up <= 1'b1;
    else if (!flp_in && !idle_in)
      up <= 1'b0;
  end
  assign flp_out = neg_in;
  assign link10_out = link_in[0] && (!neg_in || up);
  assign link100_out = link_in[1] && (!neg_in || up);
endmodule

// *** pac_negotiation_tb_top.sv ***
`timescale 1ns/1ps
module pac_negotiation_tb_top;
  import pac_pkg::*;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, neg = 0, txe = 1;
  logic [4:0] ra = 0;
  logic [15:0] wd = 0, pword = 16'h41e1;
  logic [3:0] txd = 4'h5, lag = 1, ltxd;
  logic [1:0] lk = 0;
  logic l10, l100, pv, pflp, ltxe, flp, idle, oe, s100, fd, up, xo;
  logic [15:0] pw;
  pac_word_t rdat, fw;
  logic [4:0] sa;
  int n_fail = 0, n_tests = 0;
  always #4 clk = ~clk;
  pac_negotiation #(.BREAK_CYCLES(20), .PORT_B(1'b1)) DUT (
    .CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .ADDR_STRAP_IN(4'ha),
    .MGMT_WR_IN(wr), .MGMT_RD_IN(rd), .MGMT_REG_IN(ra),
    .MGMT_WDATA_IN(wd), .MGMT_RDATA_OUT(rdat), .LINK10_IN(l10),
    .LINK100_IN(l100), .PAGE_VALID_IN(pv), .PAGE_WORD_IN(pw),
    .PARTNER_FLP_IN(pflp), .TX_EN_IN(txe), .TXD_IN(txd),
    .LINE_TX_EN_OUT(ltxe), .LINE_TXD_OUT(ltxd), .FLP_SEND_OUT(flp),
    .FLP_WORD_OUT(fw), .IDLE_SEND_OUT(idle), .MII_OE_OUT(oe),
    .SPEED100_OUT(s100), .FULL_DUPLEX_OUT(fd), .LINK_UP_OUT(up),
    .CROSSOVER_OUT(xo), .STATION_ADDR_OUT(sa));
  pac_link_partner u_partner (.clk_in(clk), .flp_in(flp), .idle_in(idle),
    .neg_in(neg), .lag_in(lag), .link_in(lk), .word_in(pword),
    .link10_out(l10), .link100_out(l100), .page_valid_out(pv),
    .flp_out(pflp), .page_word_out(pw));
  // ------------------------------
  // shared tasks
  // ------------------------------
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task wreg(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    wr = 1;
    ra = a;
    wd = d;
    @(negedge clk);
    wr = 0;
  endtask
  task rchk(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
    @(negedge clk);
    rd = 1;
    ra = a;
    @(negedge clk);
    rd = 0;
    chk(rdat & m, e);
  endtask
  task wup(input logic v);
    repeat (400) if (up !== v) @(negedge clk);
    chk(up, v);
  endtask
  task wflp;
    repeat (400) if (flp !== 1'b1) @(negedge clk);
    chk(flp, 1'b1);
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task t_reset;
    rchk(5'h00, 16'hffff, 16'h3000);
    rchk(5'h04, 16'hffff, 16'h01e1);
    rchk(5'h19, 16'hffff, 16'h8015);
    chk(sa, 5'h15);
    rchk(5'h1f, 16'hffff, 16'h0000);
  endtask
  task t_neg;
    neg = 1;
    lk = 2'b10;
    wreg(5'h00, 16'h1200);
    wflp;
    chk(fw, 16'h01e1);
    chk(ltxe, 1'b0);
    wup(1);
    chk({s100, fd}, 2'b11);
    rchk(5'h05, 16'hffff, 16'h41e1);
    rchk(5'h10, 16'h0017, 16'h0015);
    lag = 9;
    lk = 2'b01;
    wreg(5'h04, 16'h0061);
    wreg(5'h00, 16'h1200);
    wup(0);
    wup(1);
    chk({s100, fd}, 2'b01);
    lk = 0;
    wup(0);
    wflp;
    wreg(5'h04, 16'h01e1);
  endtask
  task t_pdet;
    neg = 0;
    wreg(5'h00, 16'h1200);
    lk = 2'b01;
    wup(1);
    rchk(5'h05, 16'hffff, 16'h0021);
    rchk(5'h06, 16'h0001, 16'h0000);
    rchk(5'h01, 16'h0020, 16'h0020);
    lk = 0;
    wup(0);
    lk = 2'b11;
    wflp;
    repeat (10) @(negedge clk);
    rchk(5'h06, 16'h0010, 16'h0010);
    lk = 2'b10;
    wup(1);
    rchk(5'h05, 16'hffff, 16'h0081);
  endtask
  task t_forced;
    wreg(5'h00, 16'h2100);
    repeat (3) @(negedge clk);
    chk({s100, fd, xo}, 3'b110);
    chk({ltxe, ltxd}, 5'h15);
    wreg(5'h00, 16'h0000);
    repeat (3) @(negedge clk);
    chk({s100, fd}, 2'b00);
    wreg(5'h19, 16'h4000);
    repeat (3) @(negedge clk);
    chk(xo, 1'b1);
    wreg(5'h00, 16'h0400);
    repeat (3) @(negedge clk);
    chk({oe, ltxe, idle}, 3'b001);
    wreg(5'h00, 16'h1200);
    wflp;
  endtask
  task results;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #300000;
    n_fail++;
    results;
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1;
    t_reset;
    t_neg;
    t_pdet;
    t_forced;
    results;
  end
endmodule
